// file: logic/rop_cfg.svh
`ifndef ROP_CFG_SVH
`define ROP_CFG_SVH

// Register byte offsets on the bus.
`define ROP_OFS_OPTION   8'h00
`define ROP_OFS_PINFUNC  8'h04
`define ROP_OFS_LEAD     8'h08
`define ROP_OFS_STATUS   8'h0c

// Reset values: both pins drive low after startup.
`define ROP_RST_OPTION   8'h00
`define ROP_RST_PINFUNC  8'h44
`define ROP_RST_LEAD     8'h00

// Option byte bit positions.
`define ROP_OPT_CLKHALF  2
`define ROP_OPT_RANGE    3
`define ROP_OPT_EARLY    4
`define ROP_OPT_AWAKE    7

// Pin function nibbles.
`define ROP_PIN0_LSB     0
`define ROP_PIN1_LSB     4

// Timing: core clock period and marker lead step.
`define ROP_CLK_PERIOD_NS 10
`define ROP_LEAD_STEP_US  100

`endif

// file: logic/rop_pkg.sv
`default_nettype none

package rop_pkg;

   // Function code of one auxiliary pin.
   typedef enum logic [3:0] {
      ROP_FN_OFF     = 4'h0,
      ROP_FN_GATE_LO = 4'h1,
      ROP_FN_GATE_HI = 4'h2,
      ROP_FN_MARK    = 4'h3,
      ROP_FN_LOW     = 4'h4,
      ROP_FN_HIGH    = 4'h5,
      ROP_FN_DET_HI  = 4'h6,
      ROP_FN_DET_LO  = 4'h7,
      ROP_FN_OD_REL  = 4'h8,
      ROP_FN_OD_PULL = 4'h9
   } rop_pin_fn_t;

   // Drive of one pad: level and output enable.
   typedef struct packed {
      logic out;
      logic oe;
   } rop_pad_t;

   // Ranging configuration handed to the measurement engine.
   typedef struct packed {
      logic clk_half;
      logic win_double;
      logic range_ext;
      logic early_report;
      logic stay_awake;
   } rop_rng_cfg_t;

   // Pulse marker sequencer states.
   typedef enum logic [3:0] {
      ROP_ST_IDLE = 4'h1,
      ROP_ST_LEAD = 4'h2,
      ROP_ST_ARM  = 4'h4,
      ROP_ST_EMIT = 4'h8
   } rop_mk_st_t;

endpackage

`default_nettype wire

// file: logic/rop_pin_drive.sv
`timescale 1ns/1ns
`default_nettype none

// Drives one auxiliary pin from its function code and reports gating.
module rop_pin_drive (
   // Clock and reset.
   input  wire logic           clk,
   input  wire logic           rst_n,
   // Function and sources.
   input  wire logic [3:0]     fn,
   input  wire logic           pin_in_s,
   input  wire logic           detect,
   input  wire logic           marker,
   // Results.
   output rop_pkg::rop_pad_t   pad,
   output logic                gate
);
   import rop_pkg::*;

   rop_pad_t pad_nxt;  // Next pad drive.
   logic     gate_nxt; // Next gating request.

   // Decode the function code into pad drive and gating request.
   always_comb begin
      pad_nxt  = '{out: 1'b0, oe: 1'b0};
      gate_nxt = 1'b0;
      unique case (rop_pin_fn_t'(fn))
         ROP_FN_OFF: begin
            pad_nxt = '{out: 1'b0, oe: 1'b0};
         end
         ROP_FN_GATE_LO: begin
            gate_nxt = ~pin_in_s;
         end
         ROP_FN_GATE_HI: begin
            gate_nxt = pin_in_s;
         end
         ROP_FN_MARK: begin
            pad_nxt = '{out: marker, oe: 1'b1};
         end
         ROP_FN_LOW: begin
            pad_nxt = '{out: 1'b0, oe: 1'b1};
         end
         ROP_FN_HIGH: begin
            pad_nxt = '{out: 1'b1, oe: 1'b1};
         end
         ROP_FN_DET_HI: begin
            pad_nxt = '{out: detect, oe: 1'b1};
         end
         ROP_FN_DET_LO: begin
            pad_nxt = '{out: ~detect, oe: 1'b1};
         end
         ROP_FN_OD_REL: begin
            pad_nxt = '{out: 1'b0, oe: ~detect};
         end
         ROP_FN_OD_PULL: begin
            pad_nxt = '{out: 1'b0, oe: detect};
         end
         default: begin
            pad_nxt = '{out: 1'b0, oe: 1'b0};
         end
      endcase
   end

   // Register drive and gating so both leave from flip-flops.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad  <= '{out: 1'b0, oe: 1'b0};
         gate <= 1'b0;
      end else begin
         pad  <= pad_nxt;
         gate <= gate_nxt;
      end
   end

endmodule

`default_nettype wire

// file: logic/rop_ctrl.sv
// The register offsets and register access over AHB-Lite were decided locally.
`include "rop_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module rop_ctrl #(
   parameter int LEAD_STEP_CYC = (`ROP_LEAD_STEP_US * 1000) / `ROP_CLK_PERIOD_NS
) (
   // Clock and reset.
   input  wire logic                clk,
   input  wire logic                resetn,
   // AHB-Lite slave.
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic                     hresp,
   output logic [31:0]              hrdata,
   // Auxiliary pins.
   input  wire logic                first_aux_pin_in,
   output rop_pkg::rop_pad_t        first_aux_pin_pad,
   input  wire logic                second_aux_pin_in,
   output rop_pkg::rop_pad_t        second_aux_pin_pad,
   // Measurement engine.
   input  wire logic                emit_req,
   input  wire logic                emitter_on,
   input  wire logic                object_detect,
   input  wire logic                meas_done,
   output rop_pkg::rop_rng_cfg_t    rng_cfg,
   output logic                     emit_grant,
   output logic                     collect_block,
   output logic                     abort_pulse,
   output logic                     restart_pulse,
   output logic                     report_pulse,
   output logic                     standby_allow
);
   import rop_pkg::*;

   // Reset synchroniser and the internal reset copy.
   logic       rst_meta_r;
   logic       rst_n;

   // Pin input synchronisers.
   logic [1:0] pin_meta_r;
   logic [1:0] pin_sync_r;

   // Software registers.
   logic [7:0] opt_r;
   logic [7:0] pinf_r;
   logic [7:0] lead_r;
   logic [7:0] opt_nxt;
   logic [7:0] pinf_nxt;
   logic [7:0] lead_nxt;

   // Bus data phase bookkeeping.
   logic       ph_wr_r;
   logic [7:0] ph_addr_r;
   logic       addr_ph;

   // Pin gating requests from the pin drivers.
   logic       gate0;
   logic       gate1;
   logic       gate_any;

   // Marker sequencer.
   rop_mk_st_t st_r;
   logic [31:0] cnt_r;
   logic        marker_r;

   // Cycles of lead for a lead-time value; value one is zero lead.
   function automatic logic [31:0] lead_cycles(input logic [7:0] v);
      lead_cycles = (32'(v) - 32'h1) * 32'(LEAD_STEP_CYC);
   endfunction

   // Release reset through two flip-flops.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // Bring both pin levels into the clock domain.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_r <= 2'h0;
         pin_sync_r <= 2'h0;
      end else begin
         pin_meta_r <= {second_aux_pin_in, first_aux_pin_in};
         pin_sync_r <= pin_meta_r;
      end
   end

   // An address phase is taken when selected, busy-free and ready.
   assign addr_ph = hsel & htrans[1] & hready;

   // Remember the address phase for the following data phase.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_wr_r   <= 1'b0;
         ph_addr_r <= 8'h00;
      end else begin
         ph_wr_r   <= addr_ph & hwrite;
         ph_addr_r <= haddr[7:0];
      end
   end

   // Write data lands in the data phase; later reads see it at once.
   always_comb begin
      opt_nxt  = opt_r;
      pinf_nxt = pinf_r;
      lead_nxt = lead_r;
      if (ph_wr_r) begin
         unique case (ph_addr_r)
            `ROP_OFS_OPTION:  opt_nxt  = hwdata[7:0];
            `ROP_OFS_PINFUNC: pinf_nxt = hwdata[7:0];
            `ROP_OFS_LEAD:    lead_nxt = hwdata[7:0];
            default:          opt_nxt  = opt_r;
         endcase
      end
   end

   // Store the three parameter registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opt_r  <= `ROP_RST_OPTION;
         pinf_r <= `ROP_RST_PINFUNC;
         lead_r <= `ROP_RST_LEAD;
      end else begin
         opt_r  <= opt_nxt;
         pinf_r <= pinf_nxt;
         lead_r <= lead_nxt;
      end
   end

   // Read data is fetched at the address phase, with write forwarding.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0;
      end else if (addr_ph && !hwrite) begin
         unique case (haddr[7:0])
            `ROP_OFS_OPTION:  hrdata <= {24'h0, opt_nxt};
            `ROP_OFS_PINFUNC: hrdata <= {24'h0, pinf_nxt};
            `ROP_OFS_LEAD:    hrdata <= {24'h0, lead_nxt};
            `ROP_OFS_STATUS:  hrdata <= {24'h0, st_r, marker_r, collect_block,
                                         pin_sync_r};
            default:          hrdata <= 32'h0;
         endcase
      end
   end

   // The slave never waits and always answers OKAY.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Ranging options go to the engine; bits 6, 5, 1 and 0 are left unused.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rng_cfg <= '0;
      end else begin
         rng_cfg.clk_half     <= opt_r[`ROP_OPT_CLKHALF];
         rng_cfg.win_double   <= opt_r[`ROP_OPT_CLKHALF];
         rng_cfg.range_ext    <= opt_r[`ROP_OPT_RANGE];
         rng_cfg.early_report <= opt_r[`ROP_OPT_EARLY];
         rng_cfg.stay_awake   <= opt_r[`ROP_OPT_AWAKE];
      end
   end

   // Standby is allowed only when idle and not asked to stay awake.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         standby_allow <= 1'b0;
      end else begin
         standby_allow <= ~opt_r[`ROP_OPT_AWAKE] & (st_r == ROP_ST_IDLE) & ~emit_req;
      end
   end

   rop_pin_drive u_pin0 (
      .clk      (clk),
      .rst_n    (rst_n),
      .fn       (pinf_r[`ROP_PIN0_LSB +: 4]),
      .pin_in_s (pin_sync_r[0]),
      .detect   (object_detect),
      .marker   (marker_r),
      .pad      (first_aux_pin_pad),
      .gate     (gate0)
   );

   rop_pin_drive u_pin1 (
      .clk      (clk),
      .rst_n    (rst_n),
      .fn       (pinf_r[`ROP_PIN1_LSB +: 4]),
      .pin_in_s (pin_sync_r[1]),
      .detect   (object_detect),
      .marker   (marker_r),
      .pad      (second_aux_pin_pad),
      .gate     (gate1)
   );

   // Either pin may hold off collection.
   assign gate_any = gate0 | gate1;

   // Gate level and its edges: abort on entry, restart on release.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         collect_block <= 1'b0;
         abort_pulse   <= 1'b0;
         restart_pulse <= 1'b0;
      end else begin
         collect_block <= gate_any;
         abort_pulse   <= gate_any & ~collect_block;
         restart_pulse <= ~gate_any & collect_block;
      end
   end

   // Host report: at measurement end, or at once on abort if asked.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         report_pulse <= 1'b0;
      end else begin
         report_pulse <= meas_done |
                         (opt_r[`ROP_OPT_EARLY] & gate_any & ~collect_block);
      end
   end

   // Marker sequencer: lead wait, grant, emission, then drop.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r       <= ROP_ST_IDLE;
         cnt_r      <= 32'h0;
         marker_r   <= 1'b0;
         emit_grant <= 1'b0;
      end else if (gate_any) begin
         // A gated pin abandons any pending or running pulse.
         st_r       <= ROP_ST_IDLE;
         cnt_r      <= 32'h0;
         marker_r   <= 1'b0;
         emit_grant <= 1'b0;
      end else begin
         unique case (st_r)
            ROP_ST_IDLE: begin
               if (emit_req && lead_r == 8'h00) begin
                  emit_grant <= 1'b1;
                  st_r       <= ROP_ST_ARM;
               end else if (emit_req) begin
                  marker_r <= 1'b1;
                  cnt_r    <= lead_cycles(lead_r);
                  if (lead_r == 8'h01) begin
                     emit_grant <= 1'b1;
                     st_r       <= ROP_ST_ARM;
                  end else begin
                     st_r <= ROP_ST_LEAD;
                  end
               end
            end
            ROP_ST_LEAD: begin
               if (cnt_r <= 32'h1) begin
                  emit_grant <= 1'b1;
                  st_r       <= ROP_ST_ARM;
               end else begin
                  cnt_r <= cnt_r - 32'h1;
               end
            end
            ROP_ST_ARM: begin
               // Wait for the emitter to light.
               if (emitter_on) begin
                  st_r <= ROP_ST_EMIT;
               end else if (!emit_req) begin
                  marker_r   <= 1'b0;
                  emit_grant <= 1'b0;
                  st_r       <= ROP_ST_IDLE;
               end
            end
            ROP_ST_EMIT: begin
               if (!emitter_on) begin
                  marker_r   <= 1'b0;
                  emit_grant <= 1'b0;
                  st_r       <= ROP_ST_IDLE;
               end
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// file: tb/rop_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Watches ranging options, gating pulses and emitter grant.
module rop_ctrl_chk (
   // Clock and reset.
   input wire logic                  clk,
   input wire logic                  resetn,
   // Watched signals.
   input wire rop_pkg::rop_rng_cfg_t rng_cfg,
   input wire logic                  emitter_on,
   input wire logic                  meas_done,
   input wire logic                  emit_grant,
   input wire logic                  collect_block,
   input wire logic                  abort_pulse,
   input wire logic                  restart_pulse,
   input wire logic                  report_pulse,
   input wire logic                  standby_allow
);
   import rop_pkg::*;
   // All checks use the core clock and rest during reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_WIN_DOUBLE: assert property (rng_cfg.win_double == rng_cfg.clk_half)
      else $error("window doubling differs from clock halving");
   AST_AWAKE: assert property (rng_cfg.stay_awake |-> !standby_allow)
      else $error("standby allowed while staying awake");
   AST_ABORT: assert property ($rose(collect_block) |-> abort_pulse)
      else $error("gating began without abort pulse");
   AST_RESTART: assert property ($fell(collect_block) |-> restart_pulse)
      else $error("gating ended without restart pulse");
   AST_EARLY: assert property (abort_pulse && rng_cfg.early_report |-> report_pulse)
      else $error("early report missing");
   AST_LATE: assert property (report_pulse && !rng_cfg.early_report |-> $past(meas_done))
      else $error("report before measurement end");
   AST_BLOCK: assert property (collect_block |-> !emit_grant)
      else $error("grant while collection blocked");
   AST_EMIT_END: assert property ($fell(emitter_on) |=> !emit_grant)
      else $error("grant held after emitter stopped");
endmodule
bind rop_ctrl rop_ctrl_chk chk_u (.clk(clk), .resetn(resetn), .rng_cfg(rng_cfg),
   .emitter_on(emitter_on), .meas_done(meas_done), .emit_grant(emit_grant),
   .collect_block(collect_block), .abort_pulse(abort_pulse),
   .restart_pulse(restart_pulse), .report_pulse(report_pulse),
   .standby_allow(standby_allow));
`default_nettype wire

// file: tb/rop_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
// Measurement engine: asks for a pulse, lights on grant, ends the run.
module rop_engine_model (
   // Clock and controls from the bench.
   input wire logic       clk,
   input wire logic       want,
   input wire logic [3:0] light,
   // Controller side.
   input wire logic       emit_grant,
   output logic           emit_req,
   output logic           emitter_on,
   output logic           meas_done
);
   logic [3:0] cnt_r; // Lit cycles left.
   initial begin
      {emit_req, emitter_on, meas_done, cnt_r} = 7'h0;
   end
   // A lost grant aborts the pulse at once, like a real engine.
   always @(posedge clk) begin
      meas_done <= 1'b0;
      if (emitter_on) begin
         cnt_r <= cnt_r - 4'h1;
         if (cnt_r == 4'h0 || !emit_grant) begin
            emitter_on <= 1'b0;
            emit_req   <= 1'b0;
            meas_done  <= 1'b1;
         end
      end else if (emit_req && emit_grant) begin
         emitter_on <= 1'b1;
         cnt_r      <= light;
      end else begin
         emit_req <= want && !meas_done;
      end
   end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rop_cfg.svh"
// Self-checking bench for the option and pin controller.
module tb_top;
   import rop_pkg::*;
   localparam int STEP = 4; // Short lead step keeps runs brief.
   logic         clk = 1'b0;
   logic         resetn, hsel, hwrite, want, pin0_in, pin1_in, detect;
   logic [1:0]   htrans;
   logic [3:0]   light;
   logic [31:0]  haddr, hwdata, hrdata, rd;
   logic         hreadyout, hresp, emit_req, emitter_on, meas_done, emit_grant;
   logic         collect_block, abort_pulse, restart_pulse, report_pulse, standby_allow;
   rop_pad_t     pad0, pad1;
   rop_rng_cfg_t cfg;
   int           err_count, total_checks, t, tm, tg, te;
   // Rows: code, detect, expected enable, expected level.
   logic [7:0]   rows [15] = '{8'h00, 8'h10, 8'h20, 8'h32, 8'h42, 8'h53, 8'h62, 8'h67,
                               8'h73, 8'h76, 8'h82, 8'h84, 8'h90, 8'h96, 8'h57};
   logic [7:0]   opts [4] = '{8'h04, 8'h08, 8'h10, 8'h80};
   logic [4:0]   cfgs [4] = '{5'h18, 5'h04, 5'h02, 5'h01};
   always #5 clk = ~clk;
   rop_ctrl #(.LEAD_STEP_CYC(STEP)) dut_u (.clk(clk), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .first_aux_pin_in(pin0_in), .first_aux_pin_pad(pad0),
      .second_aux_pin_in(pin1_in), .second_aux_pin_pad(pad1),
      .emit_req(emit_req), .emitter_on(emitter_on), .object_detect(detect),
      .meas_done(meas_done), .rng_cfg(cfg), .emit_grant(emit_grant),
      .collect_block(collect_block), .abort_pulse(abort_pulse),
      .restart_pulse(restart_pulse), .report_pulse(report_pulse),
      .standby_allow(standby_allow));
   rop_engine_model eng_u (.clk(clk), .want(want), .light(light), .emit_grant(emit_grant),
      .emit_req(emit_req), .emitter_on(emitter_on), .meas_done(meas_done));
   // Compares one value and counts it.
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // Waits a bounded time for ready at a rising edge.
   task automatic wait_rdy();
      int k;
      k = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1 && k < 20) begin
         @(posedge clk);
         k++;
      end
      chk("hready", 1, hreadyout);
   endtask
   // One single word transfer; read data lands in rd.
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #200000;
      err_count++;
      give_verdict();
   end
   initial begin
      {hsel, hwrite, want, detect, pin1_in, resetn} = 6'h0;
      pin0_in = 1'b1;
      {htrans, haddr, hwdata} = 66'h0;
      light = 4'h3;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      bus(1'b0, `ROP_OFS_PINFUNC, 32'h0);
      chk("pinfunc", 32'h44, rd);
      chk("pad0", 2'b01, pad0);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 0, hresp);
      // Every pin code on the first pin; the second holds code 5.
      foreach (rows[i]) begin
         detect  <= rows[i][2];
         pin0_in <= (rows[i][7:4] != 4'h2);
         bus(1'b1, `ROP_OFS_PINFUNC, {24'h0, 4'h5, rows[i][7:4]});
         repeat (4) @(posedge clk);
         chk("oe0", rows[i][1], pad0.oe);
         if (rows[i][1]) chk("out0", rows[i][0], pad0.out);
         chk("pad1", 2'b11, pad1);
      end
      foreach (opts[j]) begin
         bus(1'b1, `ROP_OFS_OPTION, {24'h0, opts[j]});
         bus(1'b0, `ROP_OFS_OPTION, 32'h0);
         chk("opt", {24'h0, opts[j]}, rd);
         chk("cfg", cfgs[j], cfg);
         chk("standby", !opts[j][7], standby_allow);
      end
      // Low pin aborts a lit pulse, with early report.
      bus(1'b1, `ROP_OFS_OPTION, 32'h10);
      bus(1'b1, `ROP_OFS_PINFUNC, 32'h41);
      light <= 4'hf;
      want  <= 1'b1;
      for (t = 0; t < 30 && emitter_on !== 1'b1; t++) @(posedge clk);
      chk("lit_on", 1, emitter_on);
      want    <= 1'b0;
      pin0_in <= 1'b0;
      for (t = 0; t < 20 && collect_block !== 1'b1; t++) @(posedge clk);
      chk("block", 1, collect_block);
      chk("abort", 1, abort_pulse);
      chk("early", 1, report_pulse);
      repeat (2) @(posedge clk);
      chk("lit", 0, emitter_on);
      // Status shows the gate, the idle sequencer and both pins low.
      bus(1'b0, `ROP_OFS_STATUS, 32'h0);
      chk("status", 32'h14, rd);
      pin0_in <= 1'b1;
      for (t = 0; t < 20 && collect_block !== 1'b0; t++) @(posedge clk);
      chk("unblock", 0, collect_block);
      chk("restart", 1, restart_pulse);
      // High on the second pin gates collection.
      bus(1'b1, `ROP_OFS_OPTION, 32'h0);
      bus(1'b1, `ROP_OFS_PINFUNC, 32'h24);
      pin1_in <= 1'b1;
      for (t = 0; t < 20 && collect_block !== 1'b1; t++) @(posedge clk);
      chk("block1", 1, collect_block);
      chk("abort1", 1, abort_pulse);
      chk("late", 0, report_pulse);
      pin1_in <= 1'b0;
      for (t = 0; t < 20 && collect_block !== 1'b0; t++) @(posedge clk);
      chk("unblock1", 0, collect_block);
      chk("restart1", 1, restart_pulse);
      // Marker lead for lead values 0 to 3.
      bus(1'b1, `ROP_OFS_PINFUNC, 32'h43);
      light <= 4'h3;
      for (int n = 0; n < 4; n++) begin
         bus(1'b1, `ROP_OFS_LEAD, n);
         want <= 1'b1;
         tm = -1;
         tg = -1;
         te = -1;
         for (t = 0; t < 60 && meas_done !== 1'b1; t++) begin
            @(posedge clk);
            if (pad0.out === 1'b1 && tm < 0) tm = t;
            if (emitter_on === 1'b1 && te < 0) te = t;
            if (emit_grant === 1'b1 && tg < 0) begin
               tg = t;
               want <= 1'b0;
            end
         end
         chk("done", 1, meas_done);
         repeat (3) @(posedge clk);
         chk("mark_off", 0, pad0.out);
         chk("grant", 1, tg >= 0);
         if (n == 0) chk("no_mark", -1, tm);
         else chk("lead", (n - 1) * STEP, te - tm);
      end
      // A reset after the last run clears the pads and restores startup values.
      resetn <= 1'b0;
      @(posedge clk);
      chk("rst_pad0", 2'b00, pad0);
      chk("rst_cfg", 0, cfg);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      chk("rst_pad1", 2'b01, pad1);
      bus(1'b0, `ROP_OFS_PINFUNC, 32'h0);
      chk("rst_pinfunc", 32'h44, rd);
      bus(1'b0, `ROP_OFS_LEAD, 32'h0);
      chk("rst_lead", 0, rd);
      give_verdict();
   end
endmodule
`default_nettype wire
